//--- design/cmc_defines.vh
// constants for the cache mode control block
// assumes inclusion by bare name from every design file of the block
`ifndef CMC_DEFINES_VH
`define CMC_DEFINES_VH

// control register layout
`define CMC_CR_W 32
`define CMC_CD_BIT 30
`define CMC_NW_BIT 29
`define CMC_CR_RST 32'h4000_0000

// fault reporting
`define CMC_ERR_W 16
`define CMC_GP_ERR_CODE 16'h0000

// two-bit line coherence states
`define CMC_ST_I 2'h0
`define CMC_ST_S 2'h1
`define CMC_ST_E 2'h2
`define CMC_ST_M 2'h3

// cache operating modes (value is {cache_disable, write_policy})
`define CMC_MODE_NORMAL 2'h0
`define CMC_MODE_BAD 2'h1
`define CMC_MODE_NOFILL 2'h2
`define CMC_MODE_NOCOH 2'h3

`endif

//--- design/cmc_snoop_resp.v
// snoop answer logic for one cache line lookup per request
// assumes the caller supplies the line state the tag lookup found
`timescale 1ns/10ps
`include "cmc_defines.vh"

module cmc_snoop_resp (
	input wire mclk, // core clock
	input wire nrst, // asynchronous reset, active low
	input wire snp_valid, // snoop request pulse
	input wire snp_inval, // snoop wants ownership
	input wire [1:0] snp_state, // line state found for snoop
	output reg snp_done_ff, // snoop answer pulse
	output reg snp_hit_ff, // line held valid
	output reg snp_hitm_ff, // line held modified, must be written back
	output reg [1:0] snp_new_state_ff // state the line moves to
);

	reg [1:0] nxt_snp_new_state;

	// next state of the snooped line, independent of the cache mode
	always @* begin
		nxt_snp_new_state = snp_state;
		if (snp_state != `CMC_ST_I) begin
			if (snp_inval) begin
				nxt_snp_new_state = `CMC_ST_I;
			end else begin
				nxt_snp_new_state = `CMC_ST_S;
			end
		end
	end

	// answer registered one cycle after the request
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			snp_done_ff <= 1'b0;
			snp_hit_ff <= 1'b0;
			snp_hitm_ff <= 1'b0;
			snp_new_state_ff <= `CMC_ST_I;
		end else begin
			snp_done_ff <= snp_valid;
			if (snp_valid) begin
				snp_hit_ff <= (snp_state != `CMC_ST_I);
				snp_hitm_ff <= (snp_state == `CMC_ST_M);
				snp_new_state_ff <= nxt_snp_new_state;
			end
		end
	end

endmodule // cmc_snoop_resp

//--- design/cmc_cache_mode_control.v
// cache operating-mode control: control register, access policy, snoops
// assumes single-cycle tag lookup results and synchronous inputs on mclk
`timescale 1ns/10ps
`include "cmc_defines.vh"

module cmc_cache_mode_control (
	input wire mclk, // core clock, 100 MHz
	input wire nrst, // asynchronous reset, active low
	input wire ctl_wr, // privileged control register write pulse
	input wire [31:0] ctl_wdata, // value to load
	output wire [31:0] ctl_rdata, // system control register contents
	output wire cache_disable_flag, // current disable flag
	output wire write_policy_flag, // current write policy flag
	output reg [1:0] cache_mode_ff, // current operating mode
	output reg general_protection_fault_ff, // fault pulse on bad write
	output reg [15:0] gp_err_code_ff, // fault error code
	input wire reduced_variant, // level: reduced implementation variant
	input wire writeback_select_input, // write-back select for variant
	input wire pg_cacheable, // page and region allow caching
	input wire mtrr_allow_modify, // range registers allow shared->modified
	input wire memory_range_type_registers_en, // range registers enabled
	input wire all_uncached, // all memory referenced as uncached
	input wire acc_valid, // access request pulse
	input wire acc_write, // access is a write
	input wire [1:0] acc_line_state, // coherence state of looked-up line
	output reg acc_done_ff, // access decision pulse
	output reg acc_from_cache_ff, // served by or written into cache
	output reg acc_mem_read_ff, // access reads system memory
	output reg acc_mem_write_ff, // write propagates to system memory
	output reg acc_fill_ff, // allocate and fill the line
	output reg acc_evict_ok_ff, // fill may replace a valid line
	output reg acc_rd_inval_ff, // issue read-invalidate bus cycle
	output reg [1:0] acc_new_state_ff, // line state after the access
	output reg strict_order_ff, // strict memory ordering in force
	input wire inv_req, // line invalidation request pulse
	input wire [1:0] inv_state, // state of line to invalidate
	output reg inv_ack_ff, // invalidation accepted pulse
	output reg inv_wb_ff, // invalidated line was modified
	input wire snp_valid, // bus snoop request pulse
	input wire snp_inval, // snoop wants ownership
	input wire [1:0] snp_state, // line state found for snoop
	output wire snp_done, // snoop answer pulse
	output wire snp_hit, // snoop hit a valid line
	output wire snp_hitm, // snoop hit a modified line
	output wire [1:0] snp_new_state // line state after the snoop
);

	reg [31:0] ctl_reg_ff;
	reg nxt_fault;
	reg [1:0] nxt_mode;
	reg nxt_from_cache;
	reg nxt_mem_read;
	reg nxt_mem_write;
	reg nxt_fill;
	reg nxt_evict_ok;
	reg nxt_rd_inval;
	reg [1:0] nxt_state;
	wire hit;
	wire wr_cd;
	wire wr_nw;

	assign cache_disable_flag = ctl_reg_ff[`CMC_CD_BIT];
	assign write_policy_flag = ctl_reg_ff[`CMC_NW_BIT];
	assign ctl_rdata = ctl_reg_ff;
	assign wr_cd = ctl_wdata[`CMC_CD_BIT];
	assign wr_nw = ctl_wdata[`CMC_NW_BIT];
	assign hit = (acc_line_state != `CMC_ST_I);

	// write check: disable clear with write policy set is refused
	always @* begin
		nxt_fault = ctl_wr & ~wr_cd & wr_nw;
		nxt_mode = cache_mode_ff;
		if (ctl_wr && !nxt_fault) begin
			nxt_mode = {wr_cd, wr_nw};
		end
	end

	// control register, reset into no-fill mode
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctl_reg_ff <= `CMC_CR_RST;
			cache_mode_ff <= `CMC_MODE_NOFILL;
			general_protection_fault_ff <= 1'b0;
			gp_err_code_ff <= `CMC_GP_ERR_CODE;
		end else begin
			general_protection_fault_ff <= nxt_fault;
			if (nxt_fault) begin
				gp_err_code_ff <= `CMC_GP_ERR_CODE;
			end
			if (ctl_wr && !nxt_fault) begin
				ctl_reg_ff <= ctl_wdata;
			end
			cache_mode_ff <= nxt_mode;
		end
	end

	// access policy per mode, hit or miss, read or write
	always @* begin
		nxt_from_cache = 1'b0;
		nxt_mem_read = 1'b0;
		nxt_mem_write = 1'b0;
		nxt_fill = 1'b0;
		nxt_evict_ok = 1'b0;
		nxt_rd_inval = 1'b0;
		nxt_state = acc_line_state;
		case (cache_mode_ff)
			`CMC_MODE_NORMAL: begin
				if (!acc_write) begin
					if (hit) begin
						nxt_from_cache = 1'b1;
					end else begin
						nxt_mem_read = 1'b1;
						if (pg_cacheable) begin
							nxt_fill = 1'b1;
							nxt_evict_ok = 1'b1;
							nxt_state = `CMC_ST_E;
						end
					end
				end else if (hit) begin
					nxt_from_cache = 1'b1;
					if (acc_line_state == `CMC_ST_S) begin
						nxt_mem_write = 1'b1;
						if (reduced_variant) begin
							if (writeback_select_input) begin
								nxt_state = `CMC_ST_E;
							end
						end else if (mtrr_allow_modify) begin
							nxt_state = `CMC_ST_M;
							nxt_rd_inval = 1'b1;
						end
					end else begin
						nxt_state = `CMC_ST_M;
					end
				end else begin
					nxt_mem_write = 1'b1;
					if (!reduced_variant && pg_cacheable) begin
						nxt_fill = 1'b1;
						nxt_evict_ok = 1'b1;
						nxt_mem_read = 1'b1;
						nxt_state = `CMC_ST_M;
					end
				end
			end
			`CMC_MODE_NOFILL, `CMC_MODE_NOCOH: begin
				// restricted caching: no allocation of any kind
				if (!acc_write) begin
					if (hit) begin
						nxt_from_cache = 1'b1;
					end else begin
						nxt_mem_read = 1'b1;
					end
				end else if (hit) begin
					nxt_from_cache = 1'b1;
					if (acc_line_state == `CMC_ST_S) begin
						nxt_mem_write = (cache_mode_ff ==
							`CMC_MODE_NOFILL);
					end else begin
						nxt_state = `CMC_ST_M;
					end
				end else begin
					nxt_mem_write = 1'b1;
				end
			end
			default: begin
				nxt_mem_read = ~acc_write;
				nxt_mem_write = acc_write;
			end
		endcase
	end

	// access decision registered one cycle after the request
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			acc_done_ff <= 1'b0;
			acc_from_cache_ff <= 1'b0;
			acc_mem_read_ff <= 1'b0;
			acc_mem_write_ff <= 1'b0;
			acc_fill_ff <= 1'b0;
			acc_evict_ok_ff <= 1'b0;
			acc_rd_inval_ff <= 1'b0;
			acc_new_state_ff <= `CMC_ST_I;
		end else begin
			acc_done_ff <= acc_valid;
			if (acc_valid) begin
				acc_from_cache_ff <= nxt_from_cache;
				acc_mem_read_ff <= nxt_mem_read;
				acc_mem_write_ff <= nxt_mem_write;
				acc_fill_ff <= nxt_fill;
				acc_evict_ok_ff <= nxt_evict_ok;
				acc_rd_inval_ff <= nxt_rd_inval;
				acc_new_state_ff <= nxt_state;
			end
		end
	end

	// ordering: set only by range registers off or all memory uncached
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			strict_order_ff <= 1'b0;
		end else begin
			strict_order_ff <= ~memory_range_type_registers_en |
				all_uncached;
		end
	end

	// line invalidations are accepted in every mode
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			inv_ack_ff <= 1'b0;
			inv_wb_ff <= 1'b0;
		end else begin
			inv_ack_ff <= inv_req;
			if (inv_req) begin
				inv_wb_ff <= (inv_state == `CMC_ST_M);
			end
		end
	end

	// snoops answered whatever the flags hold
	cmc_snoop_resp u_snoop (
		.mclk(mclk),
		.nrst(nrst),
		.snp_valid(snp_valid),
		.snp_inval(snp_inval),
		.snp_state(snp_state),
		.snp_done_ff(snp_done),
		.snp_hit_ff(snp_hit),
		.snp_hitm_ff(snp_hitm),
		.snp_new_state_ff(snp_new_state)
	);

endmodule // cmc_cache_mode_control

//--- sim/cmc_props.sv
// checker for the cache mode control ports
// assumes a bind into cmc_cache_mode_control, ports matched by name
`timescale 1ns/10ps
module cmc_props (
	input wire mclk, nrst, ctl_wr, // clock, reset, write pulse
	input wire [31:0] ctl_wdata, ctl_rdata, // control word
	input wire [1:0] cache_mode_ff, acc_line_state, inv_state, snp_state, // st
	input wire cache_disable_flag, general_protection_fault_ff, // flags
	input wire [15:0] gp_err_code_ff, // fault code
	input wire acc_valid, acc_write, acc_done_ff, acc_fill_ff, // access
	input wire acc_from_cache_ff, strict_order_ff, all_uncached, // policy
	input wire memory_range_type_registers_en, inv_req, inv_ack_ff, // inval
	input wire inv_wb_ff, snp_valid, snp_done, snp_hit, snp_hitm // snoop
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// the one refused flag pair
	wire bad_wr = ctl_wr && !ctl_wdata[30] && ctl_wdata[29];
	property p_cd_bit; cache_disable_flag == ctl_rdata[30]; endproperty
	a_cd_bit: assert property (p_cd_bit) else $error("flag off bit");
	property p_mode; cache_mode_ff == ctl_rdata[30:29]; endproperty
	a_mode: assert property (p_mode) else $error("mode off flags");
	property p_good; ctl_wr && !bad_wr |=> ctl_rdata == $past(ctl_wdata);
	endproperty
	a_good: assert property (p_good) else $error("write lost");
	property p_bad;
		bad_wr |=> general_protection_fault_ff && gp_err_code_ff == 16'h0000;
	endproperty
	a_bad: assert property (p_bad) else $error("no fault");
	property p_keep; bad_wr |=> $stable(ctl_rdata); endproperty
	a_keep: assert property (p_keep) else $error("bad write taken");
	property p_snp;
		snp_valid |=> snp_done && snp_hit == ($past(snp_state) != 2'h0)
			&& snp_hitm == ($past(snp_state) == 2'h3);
	endproperty
	a_snp: assert property (p_snp) else $error("snoop answer");
	property p_inv;
		inv_req |=> inv_ack_ff && inv_wb_ff == ($past(inv_state) == 2'h3);
	endproperty
	a_inv: assert property (p_inv) else $error("inval answer");
	property p_nofill; acc_valid && cache_mode_ff[1] |=> acc_done_ff
		&& !acc_fill_ff; endproperty
	a_nofill: assert property (p_nofill) else $error("fill");
	property p_rdhit; acc_valid && !acc_write && acc_line_state != 2'h0
		|=> acc_from_cache_ff && !acc_fill_ff; endproperty
	a_rdhit: assert property (p_rdhit) else $error("read hit");
	property p_strict; 1'b1 |=> strict_order_ff ==
		(!$past(memory_range_type_registers_en) || $past(all_uncached));
	endproperty
	a_strict: assert property (p_strict) else $error("ordering");
	c_bad: cover property (bad_wr);
	c_snp: cover property (snp_valid && cache_disable_flag);
	c_acc: cover property (acc_valid && cache_mode_ff == 2'h0);
endmodule // cmc_props

//--- sim/cmc_bus_agent.sv
// snooping bus agent on the far side of the block
// assumes the bench calls snoop() off any edge
`timescale 1ns/10ps
module cmc_bus_agent (
	input wire mclk, // core clock
	output reg snp_valid, // snoop request pulse
	output reg snp_inval, // ownership wanted
	output reg [1:0] snp_state // line state presented
);
	// idle lines at time zero
	initial begin
		{snp_valid, snp_inval, snp_state} = 4'h0;
	end
	// one snoop pulse after a gap, then scramble the released lines
	task snoop(input logic inv, input logic [1:0] st, input int gap);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		{snp_valid, snp_inval, snp_state} <= {1'b1, inv, st};
		@(posedge mclk);
		{snp_valid, snp_inval, snp_state} <= {1'b0, ~inv, ~st};
	endtask
endmodule // cmc_bus_agent

//--- sim/cmc_cache_mode_control_tb.sv
// self-checking bench for the cache mode control block
// assumes the design, checker and bus agent are compiled first
`timescale 1ns/10ps
module cmc_cache_mode_control_tb;
	reg mclk, nrst, ctl_wr, reduced_variant, writeback_select_input;
	reg pg_cacheable, mtrr_allow_modify, memory_range_type_registers_en;
	reg all_uncached, acc_valid, acc_write, inv_req;
	reg [31:0] ctl_wdata;
	reg [1:0] acc_line_state, inv_state;
	wire [31:0] ctl_rdata;
	wire [15:0] gp_err_code_ff;
	wire [1:0] cache_mode_ff, acc_new_state_ff, snp_state, snp_new_state;
	wire cache_disable_flag, write_policy_flag, general_protection_fault_ff;
	wire acc_done_ff, acc_from_cache_ff, acc_mem_read_ff, acc_mem_write_ff;
	wire acc_fill_ff, acc_evict_ok_ff, acc_rd_inval_ff, strict_order_ff;
	wire inv_ack_ff, inv_wb_ff, snp_valid, snp_inval, snp_done, snp_hit;
	wire snp_hitm;
	int errors = 0;
	int cmp_count = 0;
	cmc_cache_mode_control u_cmc_cache_mode_control (.*);
	cmc_bus_agent u_cmc_bus_agent (.*);
	// free-running 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task report_and_stop;
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		cmp_count = cmp_count + 1;
		if (got !== ex) begin
			errors = errors + 1;
			$display("MISMATCH %s exp %h got %h", nm, ex, got);
		end
	endtask
	task wr(input logic [31:0] v);
		@(posedge mclk);
		{ctl_wr, ctl_wdata} <= {1'b1, v};
		@(posedge mclk);
		ctl_wr <= 1'b0;
		#1;
	endtask
	// result {cache, mem rd, mem wr, fill, evict, rd-inval, state}
	task acc(input logic w, input logic [1:0] st, input logic [7:0] ex,
		input logic [7:0] msk);
		int i;
		logic [7:0] got;
		@(posedge mclk);
		{acc_valid, acc_write, acc_line_state} <= {1'b1, w, st};
		@(posedge mclk);
		{acc_valid, acc_line_state} <= {1'b0, ~st};
		#1;
		for (i = 0; i < 4 && acc_done_ff !== 1'b1; i++) @(posedge mclk);
		if (i == 4) begin
			errors = errors + 1;
			report_and_stop;
		end
		got = {acc_from_cache_ff, acc_mem_read_ff, acc_mem_write_ff, acc_fill_ff,
			acc_evict_ok_ff, acc_rd_inval_ff, acc_new_state_ff};
		chk("access", ex & msk, got & msk);
	endtask
	task lvl(input logic pg, input logic rv, input logic en, input logic un);
		@(posedge mclk);
		{pg_cacheable, reduced_variant} <= {pg, rv};
		{memory_range_type_registers_en, all_uncached} <= {en, un};
	endtask
	task t_ctl;
		chk("reset word", 32'h4000_0000, ctl_rdata);
		chk("reset mode", 2'h2, cache_mode_ff);
		wr(32'h0000_0000);
		chk("mode", 2'h0, {cache_disable_flag, write_policy_flag});
		wr(32'h2000_0000);
		chk("fault", 17'h10000, {general_protection_fault_ff, gp_err_code_ff});
		chk("kept", 32'h0, ctl_rdata);
		@(posedge mclk);
		#1;
		chk("fault end", 1'b0, general_protection_fault_ff);
		wr(32'h6000_0000);
		chk("mode", 2'h3, cache_mode_ff);
		acc(1'b1, 2'h1, 8'h81, 8'hff);
		acc(1'b0, 2'h0, 8'h40, 8'hff);
		wr(32'h0000_0000);
	endtask
	task t_normal;
		acc(1'b0, 2'h1, 8'h81, 8'hff);
		acc(1'b0, 2'h0, 8'h5a, 8'hff);
		acc(1'b1, 2'h0, 8'h7b, 8'h7f);
		acc(1'b1, 2'h1, 8'ha7, 8'hff);
		acc(1'b1, 2'h2, 8'h83, 8'hff);
		lvl(1'b0, 1'b1, 1'b1, 1'b0);
		acc(1'b0, 2'h0, 8'h40, 8'hff);
		acc(1'b1, 2'h1, 8'ha2, 8'hff);
		acc(1'b1, 2'h0, 8'h20, 8'h7f);
		lvl(1'b1, 1'b0, 1'b1, 1'b0);
	endtask
	task t_nofill;
		wr(32'h4000_0000);
		acc(1'b0, 2'h0, 8'h40, 8'hff);
		acc(1'b0, 2'h3, 8'h83, 8'hff);
		acc(1'b1, 2'h1, 8'ha1, 8'hff);
		acc(1'b1, 2'h2, 8'h83, 8'hff);
		acc(1'b1, 2'h0, 8'h20, 8'h7f);
	endtask
	task t_snoop;
		u_cmc_bus_agent.snoop(1'b0, 2'h3, 0);
		#1;
		chk("snoop", 5'h1d, {snp_done, snp_hit, snp_hitm, snp_new_state});
		u_cmc_bus_agent.snoop(1'b1, 2'h2, 2);
		#1;
		chk("snoop", 5'h18, {snp_done, snp_hit, snp_hitm, snp_new_state});
		u_cmc_bus_agent.snoop(1'b0, 2'h0, 0);
		#1;
		chk("snoop", 5'h10, {snp_done, snp_hit, snp_hitm, snp_new_state});
		@(posedge mclk);
		{inv_req, inv_state} <= 3'h7;
		@(posedge mclk);
		{inv_req, inv_state} <= 3'h0;
		#1;
		chk("inval", 2'h3, {inv_ack_ff, inv_wb_ff});
	endtask
	task t_strict;
		chk("order", 1'b0, strict_order_ff);
		lvl(1'b1, 1'b0, 1'b0, 1'b0);
		@(posedge mclk);
		#1;
		chk("order", 1'b1, strict_order_ff);
		lvl(1'b1, 1'b0, 1'b1, 1'b1);
		@(posedge mclk);
		#1;
		chk("order", 1'b1, strict_order_ff);
	endtask
	// reset, then scenarios in turn
	initial begin
		{nrst, ctl_wr, ctl_wdata, reduced_variant, acc_valid, acc_write} = 0;
		{writeback_select_input, pg_cacheable, mtrr_allow_modify} = 3'h7;
		{memory_range_type_registers_en, all_uncached, inv_req} = 3'h4;
		{acc_line_state, inv_state} = 4'h0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		t_ctl;
		t_normal;
		t_nofill;
		t_snoop;
		t_strict;
		report_and_stop;
	end
endmodule // cmc_cache_mode_control_tb
bind cmc_cache_mode_control cmc_props u_cmc_props (.*);
